// *** src/sldrv_top.sv ***
// two-channel peak/hold solenoid driver with register port and interrupt
`timescale 1ns/1ps
module sldrv_top #(
  parameter int SLOW_DIV = sldrv_pkg::SLOW_DIV,
  parameter int STARTUP_TICKS = sldrv_pkg::STARTUP_TICKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [sldrv_pkg::NCH-1:0] on_in,
  input wire logic [sldrv_pkg::NCH-1:0] stage_fault,
  input wire logic [sldrv_pkg::SENSE_W-1:0] sense0_mv,
  input wire logic [sldrv_pkg::SENSE_W-1:0] sense1_mv,
  output logic [sldrv_pkg::NCH-1:0] hs_drive,
  output logic [sldrv_pkg::NCH-1:0] ls_on,
  output logic [sldrv_pkg::NCH-1:0] channel_indicator,
  output logic [sldrv_pkg::NCH-1:0] fault_od_out,
  output logic [sldrv_pkg::NCH-1:0] fault_od_oe,
  output logic irq,
  input wire logic [sldrv_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sldrv_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [sldrv_pkg::DATA_W-1:0] reg_rdata
);
  localparam int NCH = sldrv_pkg::NCH;
  localparam int DW = sldrv_pkg::DAC_W;
  localparam int IW = sldrv_pkg::INT_W;

  logic startup_ready;
  logic slow_tick;
  logic fast_tick;
  logic blink;
  logic [NCH-1:0][DW-1:0] peak_code_reg;
  logic [NCH-1:0][DW-1:0] hold_code_reg;
  logic [IW-1:0] int_stat_reg;
  logic [IW-1:0] int_mask_reg;
  logic [IW-1:0] int_set;
  logic [IW-1:0] int_clr;
  logic [NCH-1:0] fault_d_reg;
  logic ready_d_reg;
  logic [NCH-1:0] ls_reg;
  logic [NCH-1:0] fault_oe_reg;
  logic [sldrv_pkg::DATA_W-1:0] rdata_reg;
  logic [sldrv_pkg::DATA_W-1:0] rdata_next;
  logic [NCH-1:0] channel_sleep_n;
  logic [NCH-1:0] hold_phase;
  logic [NCH-1:0] hold_entered;
  logic [NCH-1:0] comp_out;
  logic [NCH-1:0][sldrv_pkg::SENSE_W-1:0] sense_mv;

  // register index decode for the reference writes; the read path decodes reg_addr in its own case
  function automatic logic ref_hit(input logic [sldrv_pkg::ADDR_W-1:0] a, input int idx);
    ref_hit = a == (idx == 0 ? sldrv_pkg::OFF_REF0 : sldrv_pkg::OFF_REF1);
  endfunction

  function automatic logic [sldrv_pkg::DATA_W-1:0] ref_word(input logic [DW-1:0] pk, input logic [DW-1:0] hd);
    logic [sldrv_pkg::DATA_W-1:0] w;
    w = '0;
    w[sldrv_pkg::REF_PEAK_LSB +: DW] = pk;
    w[sldrv_pkg::REF_HOLD_LSB +: DW] = hd;
    ref_word = w;
  endfunction

  assign sense_mv[0] = sense0_mv;
  assign sense_mv[1] = sense1_mv;

  sldrv_timebase #(
    .SLOW_DIV(SLOW_DIV),
    .STARTUP_TICKS(STARTUP_TICKS)
  ) u_timebase (
    .clk(clk),
    .rst_n(rst_n),
    .startup_ready(startup_ready),
    .slow_tick(slow_tick),
    .fast_tick(fast_tick),
    .blink(blink)
  );

  sldrv_ch_if ch_if[NCH] ();

  // identical, independent channels
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign ch_if[g].startup_ready = startup_ready;
      assign ch_if[g].slow_tick = slow_tick;
      assign ch_if[g].fast_tick = fast_tick;
      assign ch_if[g].blink = blink;
      assign ch_if[g].on_req = on_in[g];
      assign ch_if[g].fault = stage_fault[g];
      assign ch_if[g].sense_mv = sense_mv[g];
      assign ch_if[g].peak_code = peak_code_reg[g];
      assign ch_if[g].hold_code = hold_code_reg[g];
      assign channel_sleep_n[g] = ch_if[g].channel_sleep_n;
      assign hold_phase[g] = ch_if[g].hold_phase;
      assign hold_entered[g] = ch_if[g].hold_entered;
      assign comp_out[g] = ch_if[g].comp_out;
      assign hs_drive[g] = ch_if[g].hs_drive;
      assign channel_indicator[g] = ch_if[g].indicator;
      sldrv_channel u_channel (
        .clk(clk),
        .rst_n(rst_n),
        .ch(ch_if[g].chan)
      );
    end
  endgenerate

  // low side on after startup; fault pins pull low only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ls_reg <= '0;
      fault_oe_reg <= '0;
    end else begin
      ls_reg <= {NCH{startup_ready}};
      fault_oe_reg <= stage_fault;
    end
  end
  assign ls_on = ls_reg;
  assign fault_od_out = '0;
  assign fault_od_oe = fault_oe_reg;

  // reference settings written by the host
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      peak_code_reg <= {NCH{sldrv_pkg::PEAK_CODE_RST}};
      hold_code_reg <= {NCH{sldrv_pkg::HOLD_CODE_RST}};
    end else if (reg_we) begin
      for (int i = 0; i < NCH; i++) begin
        if (ref_hit(reg_addr, i)) begin
          peak_code_reg[i] <= reg_wdata[sldrv_pkg::REF_PEAK_LSB +: DW];
          hold_code_reg[i] <= reg_wdata[sldrv_pkg::REF_HOLD_LSB +: DW];
        end
      end
    end
  end

  // event edges for the interrupt status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_d_reg <= '0;
      ready_d_reg <= 1'b0;
    end else begin
      fault_d_reg <= stage_fault;
      ready_d_reg <= startup_ready;
    end
  end

  always_comb begin
    int_set = '0;
    int_set[sldrv_pkg::INT_FAULT +: NCH] = stage_fault & ~fault_d_reg;
    int_set[sldrv_pkg::INT_HOLD +: NCH] = hold_entered;
    int_set[sldrv_pkg::INT_READY] = startup_ready & ~ready_d_reg;
    int_clr = (reg_we && reg_addr == sldrv_pkg::OFF_INT_STAT) ? reg_wdata[IW-1:0] : '0;
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_reg <= '0;
    end else begin
      int_stat_reg <= (int_stat_reg & ~int_clr) | int_set;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_mask_reg <= sldrv_pkg::INT_MASK_RST;
    end else if (reg_we && reg_addr == sldrv_pkg::OFF_INT_MASK) begin
      int_mask_reg <= reg_wdata[IW-1:0];
    end
  end

  assign irq = |(int_stat_reg & int_mask_reg);

  // read data stand only in the cycle after the read strobe
  always_comb begin
    rdata_next = '0;
    if (reg_re) begin
      case (reg_addr)
        sldrv_pkg::OFF_REF0: rdata_next = ref_word(peak_code_reg[0], hold_code_reg[0]);
        sldrv_pkg::OFF_REF1: rdata_next = ref_word(peak_code_reg[1], hold_code_reg[1]);
        sldrv_pkg::OFF_STATE: begin
          rdata_next[sldrv_pkg::ST_READY] = startup_ready;
          rdata_next[sldrv_pkg::ST_SLEEP_N +: NCH] = channel_sleep_n;
          rdata_next[sldrv_pkg::ST_HOLD +: NCH] = hold_phase;
          rdata_next[sldrv_pkg::ST_FAULT +: NCH] = stage_fault;
          rdata_next[sldrv_pkg::ST_HS +: NCH] = hs_drive;
          rdata_next[sldrv_pkg::ST_CMP +: NCH] = comp_out;
        end
        sldrv_pkg::OFF_INT_STAT: rdata_next[IW-1:0] = int_stat_reg;
        sldrv_pkg::OFF_INT_MASK: rdata_next[IW-1:0] = int_mask_reg;
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata = rdata_reg;

  // checks on the channel behaviour seen at the top
  sequence s_activate0;
    $rose(!channel_sleep_n[0]);
  endsequence

  sequence s_peak_phase0;
    !hold_phase[0] [*8];
  endsequence

  property p_nand_enable;
    @(posedge clk) disable iff (!rst_n)
      (on_in[0] && startup_ready) != channel_sleep_n[0];
  endproperty
  a_nand_enable: assert property (p_nand_enable) else $error("sleep control is not the nand");

  property p_peak_first;
    @(posedge clk) disable iff (!rst_n)
      s_activate0 |-> s_peak_phase0;
  endproperty
  a_peak_first: assert property (p_peak_first) else $error("activation did not start in peak");

  // cycles in a row with the switch on while the comparator reads above reference
  localparam int COMP_HI_MAX = sldrv_pkg::BLANK_TICKS * sldrv_pkg::FAST_DIV + 4;
  logic [9:0] comp_hi_cnt_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      comp_hi_cnt_reg <= 10'h000;
    end else if (!(hs_drive[0] && comp_out[0])) begin
      comp_hi_cnt_reg <= 10'h000;
    end else if (comp_hi_cnt_reg != 10'h3ff) begin
      comp_hi_cnt_reg <= comp_hi_cnt_reg + 10'h001;
    end
  end

  // only blanking may keep the switch on above reference
  property p_comp_stops;
    @(posedge clk) disable iff (!rst_n)
      comp_hi_cnt_reg <= 10'(COMP_HI_MAX);
  endproperty
  a_comp_stops: assert property (p_comp_stops) else $error("switch stayed on above reference");

  property p_status_follow;
    @(posedge clk) disable iff (!rst_n)
      !stage_fault[0] |=> channel_indicator[0] == $past(channel_sleep_n[0]);
  endproperty
  a_status_follow: assert property (p_status_follow) else $error("status does not follow sleep");

  property p_status_blink;
    @(posedge clk) disable iff (!rst_n)
      stage_fault[1] |=> channel_indicator[1] == $past(blink);
  endproperty
  a_status_blink: assert property (p_status_blink) else $error("status not blinking on fault");

  property p_fault_od;
    @(posedge clk) disable iff (!rst_n)
      stage_fault[1] ##1 stage_fault[1] |-> fault_od_oe[1] && !fault_od_out[1];
  endproperty
  a_fault_od: assert property (p_fault_od) else $error("fault output not pulling low");

  property p_low_side_stays;
    @(posedge clk) disable iff (!rst_n)
      $rose(startup_ready) |=> ls_on == 2'h3 [*8];
  endproperty
  a_low_side_stays: assert property (p_low_side_stays) else $error("low side not held on");

  property p_disabled_at_start;
    @(posedge clk) disable iff (!rst_n)
      !startup_ready |-> channel_sleep_n == 2'h3 && hs_drive == 2'h0;
  endproperty
  a_disabled_at_start: assert property (p_disabled_at_start) else $error("channel on before startup");

  property p_ready_once;
    @(posedge clk) disable iff (!rst_n)
      startup_ready |=> startup_ready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready fell after startup");

  property p_off_stops;
    @(posedge clk) disable iff (!rst_n)
      channel_sleep_n[0] |=> !hs_drive[0] && !hold_phase[0];
  endproperty
  a_off_stops: assert property (p_off_stops) else $error("disabled channel still switching");

  property p_ref_write;
    @(posedge clk) disable iff (!rst_n)
      reg_we && reg_addr == sldrv_pkg::OFF_REF0 |=> hold_code_reg[0] == $past(reg_wdata[sldrv_pkg::REF_HOLD_LSB +: DW]);
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("reference write not applied");

  property p_set_wins;
    @(posedge clk) disable iff (!rst_n)
      int_set[sldrv_pkg::INT_READY] |=> int_stat_reg[sldrv_pkg::INT_READY];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost against clear");

  property p_read_once;
    @(posedge clk) disable iff (!rst_n)
      !reg_re |=> reg_rdata == '0;
  endproperty
  a_read_once: assert property (p_read_once) else $error("read data outside its cycle");

  property p_hold_event;
    @(posedge clk) disable iff (!rst_n)
      hold_entered[0] |=> hold_phase[0] && int_stat_reg[sldrv_pkg::INT_HOLD];
  endproperty
  a_hold_event: assert property (p_hold_event) else $error("hold entry not flagged");

  property p_ls_before_ready;
    @(posedge clk) disable iff (!rst_n)
      !startup_ready |=> ls_on == 2'h0;
  endproperty
  a_ls_before_ready: assert property (p_ls_before_ready) else $error("low side on before startup");

  property p_blank_on;
    @(posedge clk) disable iff (!rst_n)
      $rose(hs_drive[0]) |-> (hs_drive[0] || channel_sleep_n[0]) [*8];
  endproperty
  a_blank_on: assert property (p_blank_on) else $error("switch left during blanking");

  property p_second_nand;
    @(posedge clk) disable iff (!rst_n)
      (on_in[1] && startup_ready) != channel_sleep_n[1];
  endproperty
  a_second_nand: assert property (p_second_nand) else $error("second channel sleep control wrong");
endmodule

// *** src/sldrv_pkg.sv ***
// constants shared by the solenoid peak/hold driver
package sldrv_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NCH = 2;
  localparam int DAC_W = 6;
  localparam int SENSE_W = 8;
  localparam int CMP_W = 11;

  localparam logic [7:0] OFF_REF0 = 8'h00;
  localparam logic [7:0] OFF_REF1 = 8'h04;
  localparam logic [7:0] OFF_STATE = 8'h08;
  localparam logic [7:0] OFF_INT_STAT = 8'h0c;
  localparam logic [7:0] OFF_INT_MASK = 8'h10;

  localparam int REF_PEAK_LSB = 0;
  localparam int REF_HOLD_LSB = 8;
  localparam logic [5:0] PEAK_CODE_RST = 6'h1b;
  localparam logic [5:0] HOLD_CODE_RST = 6'h05;

  localparam int ST_READY = 0;
  localparam int ST_SLEEP_N = 1;
  localparam int ST_HOLD = 3;
  localparam int ST_FAULT = 5;
  localparam int ST_HS = 7;
  localparam int ST_CMP = 9;

  localparam int INT_W = 5;
  localparam int INT_FAULT = 0;
  localparam int INT_HOLD = 2;
  localparam int INT_READY = 4;
  localparam logic [INT_W-1:0] INT_MASK_RST = 5'h00;

  localparam logic [CMP_W-1:0] DAC_STEP_MV = 11'h020;
  localparam int SENSE_GAIN_SHIFT = 3;

  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
  localparam int FAST_OSC_HZ = 25000000;
  localparam int FAST_DIV = CLK_HZ / FAST_OSC_HZ;
  localparam int STARTUP_PRESCALE = 4;
  localparam int STARTUP_TIME_US = 2000;
  localparam int STARTUP_TICKS = STARTUP_TIME_US * (FAST_OSC_HZ / 1000) / (STARTUP_PRESCALE * 1000);
  localparam int SLOW_OSC_HZ = 2048;
  localparam int SLOW_DIV = CLK_HZ / SLOW_OSC_HZ;
  localparam int PEAK_TIME_MS = 50;
  localparam int PEAK_TICKS = (PEAK_TIME_MS * SLOW_OSC_HZ + 999) / 1000;
  localparam int BLINK_PRESCALE = 64;
  localparam int BLINK_HZ = 1;
  localparam int BLINK_HALF_TICKS = SLOW_OSC_HZ / BLINK_PRESCALE / (2 * BLINK_HZ);
  localparam int BLANK_TIME_NS = 3000;
  localparam int BLANK_TICKS = (BLANK_TIME_NS * (FAST_OSC_HZ / 1000000) + 999) / 1000;
endpackage

// *** src/sldrv_ch_if.sv ***
// signals between the top and one regulation channel
`timescale 1ns/1ps
interface sldrv_ch_if;
  logic startup_ready;
  logic slow_tick;
  logic fast_tick;
  logic blink;
  logic on_req;
  logic fault;
  logic [sldrv_pkg::SENSE_W-1:0] sense_mv;
  logic [sldrv_pkg::DAC_W-1:0] peak_code;
  logic [sldrv_pkg::DAC_W-1:0] hold_code;
  logic channel_sleep_n;
  logic hold_phase;
  logic hold_entered;
  logic hs_drive;
  logic indicator;
  logic comp_out;
  modport ctl (
    output startup_ready, slow_tick, fast_tick, blink, on_req, fault, sense_mv, peak_code, hold_code,
    input channel_sleep_n, hold_phase, hold_entered, hs_drive, indicator, comp_out
  );
  modport chan (
    input startup_ready, slow_tick, fast_tick, blink, on_req, fault, sense_mv, peak_code, hold_code,
    output channel_sleep_n, hold_phase, hold_entered, hs_drive, indicator, comp_out
  );
endinterface

// *** src/sldrv_timebase.sv ***
// oscillator dividers, startup counter and slow blink generator
`timescale 1ns/1ps
module sldrv_timebase #(
  parameter int SLOW_DIV = sldrv_pkg::SLOW_DIV,
  parameter int STARTUP_TICKS = sldrv_pkg::STARTUP_TICKS
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic startup_ready,
  output logic slow_tick,
  output logic fast_tick,
  output logic blink
);
  localparam int SW = $clog2(STARTUP_TICKS + 1);
  localparam int DW = $clog2(SLOW_DIV + 1);
  logic [1:0] fast_oscillator_reg;
  logic [1:0] prescale_reg;
  logic [SW-1:0] startup_counter_reg;
  logic [DW-1:0] slow_oscillator_reg;
  logic [5:0] div64_reg;
  logic [3:0] blink_cnt_reg;
  logic ready_reg;
  logic blink_reg;
  logic start_tick;
  logic slow64_tick;

  assign fast_tick = fast_oscillator_reg == 2'(sldrv_pkg::FAST_DIV - 1);
  assign start_tick = fast_tick && prescale_reg == 2'(sldrv_pkg::STARTUP_PRESCALE - 1);
  assign slow_tick = slow_oscillator_reg == DW'(SLOW_DIV - 1);
  assign slow64_tick = slow_tick && div64_reg == 6'(sldrv_pkg::BLINK_PRESCALE - 1);
  assign startup_ready = ready_reg;
  assign blink = blink_reg;

  // fast oscillator and its divided-by-4 startup clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_oscillator_reg <= 2'h0;
      prescale_reg <= 2'h0;
    end else begin
      fast_oscillator_reg <= fast_tick ? 2'h0 : fast_oscillator_reg + 2'h1;
      if (fast_tick) begin
        prescale_reg <= prescale_reg + 2'h1;
      end
    end
  end

  // startup counter holds ready low, then gives one rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      startup_counter_reg <= '0;
      ready_reg <= 1'b0;
    end else if (!ready_reg && start_tick) begin
      if (startup_counter_reg == SW'(STARTUP_TICKS - 1)) begin
        ready_reg <= 1'b1;
      end else begin
        startup_counter_reg <= startup_counter_reg + SW'(1);
      end
    end
  end

  // slow oscillator, divide by 64, then toggle for the blink square wave
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_oscillator_reg <= '0;
      div64_reg <= 6'h00;
      blink_cnt_reg <= 4'h0;
      blink_reg <= 1'b0;
    end else begin
      slow_oscillator_reg <= slow_tick ? '0 : slow_oscillator_reg + DW'(1);
      if (slow_tick) begin
        div64_reg <= div64_reg + 6'h01;
      end
      if (slow64_tick) begin
        if (blink_cnt_reg == 4'(sldrv_pkg::BLINK_HALF_TICKS - 1)) begin
          blink_cnt_reg <= 4'h0;
          blink_reg <= ~blink_reg;
        end else begin
          blink_cnt_reg <= blink_cnt_reg + 4'h1;
        end
      end
    end
  end
endmodule

// *** src/sldrv_channel.sv ***
// one peak/hold current regulation channel
`timescale 1ns/1ps
module sldrv_channel #(
  parameter int PEAK_TICKS = sldrv_pkg::PEAK_TICKS,
  parameter int BLANK_TICKS = sldrv_pkg::BLANK_TICKS
) (
  input wire logic clk,
  input wire logic rst_n,
  sldrv_ch_if.chan ch
);
  typedef enum logic [2:0] {
    SW_OFF = 3'b001,
    SW_DRIVE = 3'b010,
    SW_FREEWHEEL = 3'b100
  } sldrv_sw_e;

  localparam int CW = sldrv_pkg::CMP_W;
  sldrv_sw_e state_reg;
  sldrv_sw_e state_next;
  logic [7:0] peak_cnt_reg;
  logic hold_reg;
  logic [6:0] blank_cnt_reg;
  logic hs_reg;
  logic ind_reg;
  logic active;
  logic blank_done;
  logic peak_end;
  logic [sldrv_pkg::DAC_W-1:0] ref_code;
  logic [CW-1:0] ref_mv;
  logic [CW-1:0] sense_amp;
  logic coil_current_comparator;

  assign ch.channel_sleep_n = ~(ch.startup_ready & ch.on_req);
  assign active = ~ch.channel_sleep_n;
  assign peak_end = active && !hold_reg && ch.slow_tick && peak_cnt_reg == 8'(PEAK_TICKS - 1);
  assign ref_code = hold_reg ? ch.hold_code : ch.peak_code;
  assign ref_mv = CW'(ref_code) * sldrv_pkg::DAC_STEP_MV;
  assign sense_amp = CW'(ch.sense_mv) << sldrv_pkg::SENSE_GAIN_SHIFT;
  assign coil_current_comparator = sense_amp >= ref_mv;
  assign blank_done = blank_cnt_reg == 7'(BLANK_TICKS);
  assign ch.hold_phase = hold_reg;
  assign ch.hold_entered = peak_end;
  assign ch.hs_drive = hs_reg;
  assign ch.indicator = ind_reg;
  assign ch.comp_out = coil_current_comparator;

  // peak timer restarts on each activation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      peak_cnt_reg <= 8'h00;
      hold_reg <= 1'b0;
    end else if (!active) begin
      peak_cnt_reg <= 8'h00;
      hold_reg <= 1'b0;
    end else if (peak_end) begin
      hold_reg <= 1'b1;
    end else if (!hold_reg && ch.slow_tick) begin
      peak_cnt_reg <= peak_cnt_reg + 8'h01;
    end
  end

  // comparator is ignored during blanking after each switch-on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blank_cnt_reg <= 7'h00;
    end else if (state_reg != SW_DRIVE) begin
      blank_cnt_reg <= 7'h00;
    end else if (!blank_done && ch.fast_tick) begin
      blank_cnt_reg <= blank_cnt_reg + 7'h01;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SW_OFF: begin
        if (active) begin
          state_next = SW_DRIVE;
        end
      end
      SW_DRIVE: begin
        if (!active) begin
          state_next = SW_OFF;
        end else if (blank_done && coil_current_comparator) begin
          state_next = SW_FREEWHEEL;
        end
      end
      SW_FREEWHEEL: begin
        if (!active) begin
          state_next = SW_OFF;
        end else if (!coil_current_comparator) begin
          state_next = SW_DRIVE;
        end
      end
      default: state_next = SW_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SW_OFF;
      hs_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      hs_reg <= state_next == SW_DRIVE;
    end
  end

  // status pin: sleep level normally, blink on fault
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ind_reg <= 1'b1;
    end else begin
      ind_reg <= ch.fault ? ch.blink : ch.channel_sleep_n;
    end
  end

  property p_hold_after_peak;
    @(posedge clk) disable iff (!rst_n)
      $rose(hold_reg) |-> $past(peak_cnt_reg) == 8'(PEAK_TICKS - 1) && $past(active);
  endproperty
  a_hold_after_peak: assert property (p_hold_after_peak) else $error("hold entered before peak time");

  property p_ref_select;
    @(posedge clk) disable iff (!rst_n)
      active |-> ref_mv == (hold_reg ? CW'(ch.hold_code) : CW'(ch.peak_code)) * sldrv_pkg::DAC_STEP_MV;
  endproperty
  a_ref_select: assert property (p_ref_select) else $error("wrong reference selected");
endmodule

// *** tb/sldrv_coil.sv ***
// behavioural coil: sensed voltage ramps while driven and decays while freewheeling
`timescale 1ns/1ps
module sldrv_coil (
  input wire logic clk,
  input wire logic drive,
  output logic [7:0] sense_mv
);
  logic [1:0] div_reg = 2'h0;
  logic [7:0] sense_reg = 8'h00;
  assign sense_mv = sense_reg;
  // one step every four clocks, capped below the largest reference
  always @(posedge clk) begin
    div_reg <= div_reg + 2'h1;
    if (div_reg == 2'h0 && drive && sense_reg < 8'hc8) sense_reg <= sense_reg + 8'h01;
    else if (div_reg == 2'h0 && !drive && sense_reg != 8'h00) sense_reg <= sense_reg - 8'h01;
  end
endmodule

// *** tb/sldrv_top_test.sv ***
// self-checking bench for the two-channel solenoid driver
`timescale 1ns/1ps
module sldrv_top_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] on_in = 2'h1;
  logic [1:0] stage_fault = 2'h0;
  logic [7:0] sense0_mv, sense1_mv;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, d;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic irq;
  logic [1:0] hs_drive, ls_on, channel_indicator, fault_od_out, fault_od_oe;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  int t0, n;
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  sldrv_top #(.SLOW_DIV(8), .STARTUP_TICKS(4)) sldrv_top_i (.clk(clk), .rst_n(rst_n), .on_in(on_in),
    .stage_fault(stage_fault), .sense0_mv(sense0_mv), .sense1_mv(sense1_mv), .hs_drive(hs_drive),
    .ls_on(ls_on), .channel_indicator(channel_indicator), .fault_od_out(fault_od_out),
    .fault_od_oe(fault_od_oe), .irq(irq), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata));
  sldrv_coil sldrv_coil_i0 (.clk(clk), .drive(hs_drive[0]), .sense_mv(sense0_mv));
  sldrv_coil sldrv_coil_i1 (.clk(clk), .drive(hs_drive[1]), .sense_mv(sense1_mv));
  task automatic stop_test();
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask
  // polls until the hold reference is selected; 103 slow ticks of 8 clocks each
  task automatic hold_wait();
    d = 32'h0;
    for (int i = 0; i < 600 && d[sldrv_pkg::ST_HOLD] !== 1'b1; i++) rd(sldrv_pkg::OFF_STATE);
    chk(32'(cyc - t0 >= 812 && cyc - t0 <= 840), 32'h1);
  endtask
  task automatic wait_ind(input logic v);
    for (n = 0; n < 9000 && channel_indicator[1] !== v; n++) tick(1);
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t0 = cyc;
    tick(50);
    chk(hs_drive, 2'h0);
    chk(channel_indicator, 2'h3);
    chk(ls_on, 2'h0);
    rdchk(sldrv_pkg::OFF_REF0, 32'h0000051b);
    rdchk(sldrv_pkg::OFF_INT_MASK, 32'h0);
    d = 32'h0;
    for (int i = 0; i < 100 && d[sldrv_pkg::ST_READY] !== 1'b1; i++) rd(sldrv_pkg::OFF_STATE);
    chk(32'(cyc - t0 >= 62 && cyc - t0 <= 72), 32'h1);
    tick(2);
    chk(ls_on, 2'h3);
    rdchk(sldrv_pkg::OFF_INT_STAT, 32'h10);
    @(posedge clk);
    on_in <= 2'h0;
    wr(sldrv_pkg::OFF_INT_STAT, 32'h1f);
    rdchk(sldrv_pkg::OFF_INT_STAT, 32'h0);
    tick(300);
    @(posedge clk);
    on_in <= 2'h1;
    t0 = cyc;
    tick(3);
    chk(hs_drive, 2'h1);
    chk(channel_indicator, 2'h2);
    // coil reaches 864/8 = 108 after about 432 clocks
    for (n = 0; n < 1000 && hs_drive[0] !== 1'b0; n++) tick(1);
    chk(32'(n >= 415 && n <= 450), 32'h1);
    hold_wait();
    rdchk(sldrv_pkg::OFF_INT_STAT, 32'h04);
    wr(sldrv_pkg::OFF_INT_MASK, 32'h04);
    chk(irq, 1'b1);
    wr(sldrv_pkg::OFF_INT_MASK, 32'h00);
    chk(irq, 1'b0);
    wr(sldrv_pkg::OFF_INT_MASK, 32'h04);
    wr(sldrv_pkg::OFF_INT_STAT, 32'h04);
    chk(irq, 1'b0);
    wr(sldrv_pkg::OFF_REF0, 32'h00003f1b);
    tick(400);
    chk(hs_drive[0], 1'b1);
    rd(sldrv_pkg::OFF_STATE);
    chk(d[sldrv_pkg::ST_CMP], 1'b0);
    wr(sldrv_pkg::OFF_REF0, 32'h0000001b);
    tick(400);
    chk(hs_drive[0], 1'b0);
    rd(sldrv_pkg::OFF_STATE);
    chk(d[sldrv_pkg::ST_CMP], 1'b1);
    @(posedge clk);
    on_in <= 2'h0;
    tick(2);
    chk(hs_drive, 2'h0);
    chk(channel_indicator, 2'h3);
    rd(sldrv_pkg::OFF_STATE);
    chk(d[sldrv_pkg::ST_HOLD], 1'b0);
    wr(sldrv_pkg::OFF_REF0, 32'h0000051b);
    @(posedge clk);
    on_in <= 2'h1;
    t0 = cyc;
    hold_wait();
    @(posedge clk);
    stage_fault <= 2'h2;
    tick(2);
    chk(fault_od_oe, 2'h2);
    chk(fault_od_out, 2'h0);
    wait_ind(1'b0);
    wait_ind(1'b1);
    wait_ind(1'b0);
    // half period is 16 ticks of slow/64, 8192 clocks here
    chk(32'(n >= 8185 && n <= 8200), 32'h1);
    chk(channel_indicator[0], 1'b0);
    @(posedge clk);
    stage_fault <= 2'h0;
    tick(3);
    chk(channel_indicator[1], 1'b1);
    rdchk(8'h20, 32'h0);
    stop_test();
  end
endmodule
